// [rsf_pkg.sv]
// Constants and carrier types for the reset cause flags and power-on reset
package rsf_pkg;

	// Special-function address of the cause register
	localparam logic [19:0] RSF_CAUSE_ADDR = 20'hFFFA8;
	// Address chosen for the parity reset disable control
	localparam logic [19:0] RSF_PARDIS_ADDR = 20'hFFFA9;

	// Bit positions inside the cause register
	localparam int RSF_BIT_ILLEGAL = 7;
	localparam int RSF_BIT_WATCHDOG = 4;
	localparam int RSF_BIT_PARITY = 2;
	localparam int RSF_BIT_ACCESS = 1;
	localparam int RSF_BIT_LOWVOLT = 0;
	// Bit position of the disable control in its own register
	localparam int RSF_BIT_PARDIS = 0;

	// Reset values
	localparam logic [7:0] RSF_CAUSE_RESET = 8'h00;
	localparam logic RSF_PARDIS_RESET = 1'b0;
	localparam logic [7:0] RSF_READ_IDLE = 8'h00;

	// Opcode byte that counts as an illegal instruction
	localparam logic [7:0] RSF_ILLEGAL_OPCODE = 8'hFF;

	// Internal reset stretch after the source goes away
	localparam int RSF_CLK_PERIOD_NS = 25;
	localparam int RSF_HOLD_TIME_NS = 1000;
	localparam int RSF_HOLD_CYCLES =
		(RSF_HOLD_TIME_NS + RSF_CLK_PERIOD_NS - 1) / RSF_CLK_PERIOD_NS;

	// Synchroniser depth for pins and comparator levels
	localparam int RSF_SYNC_STAGES = 2;

	// Reset sequencer states
	typedef enum logic [1:0] {
		RSF_ST_POWER,
		RSF_ST_HOLD,
		RSF_ST_RUN
	} rsf_state_e;

	// Internal reset requests, one-cycle pulses from same-clock logic
	typedef struct packed {
		logic exec_valid;
		logic [7:0] exec_opcode;
		logic debug_active;
		logic watchdog_timer;
		logic ram_parity;
		logic bad_access;
		logic low_voltage_detector;
	} rsf_src_s;

	// Processor access to the special-function space
	typedef struct packed {
		logic rd;
		logic wr;
		logic bit_access;
		logic [19:0] addr;
		logic [7:0] wdata;
	} rsf_bus_s;

endpackage : rsf_pkg

// [rsf_reset_cause.sv]
// Reset cause flag register with power-on internal reset sequencer
module rsf_reset_cause #(
	parameter int HOLD_CYCLES = rsf_pkg::RSF_HOLD_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ext_reset_n_i,
	input wire logic supply_rise_ok_i,
	input wire logic supply_fall_low_i,
	input wire rsf_pkg::rsf_src_s src_i,
	input wire rsf_pkg::rsf_bus_s bus_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic internal_reset_o,
	output logic por_reset_o,
	output logic parity_reset_disable_o,
	output logic [7:0] reset_cause_flags_o
);
	import rsf_pkg::*;

	// Refuse a hold count the counter cannot express
	generate
		if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) begin : g_bad_hold
			$error("HOLD_CYCLES must lie in 1..65535");
		end
	endgenerate

	localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);

	// Synchroniser chains: pin and two comparator levels
	logic [RSF_SYNC_STAGES-1:0] ext_sync;
	logic [RSF_SYNC_STAGES-1:0] rise_sync;
	logic [RSF_SYNC_STAGES-1:0] fall_sync;
	logic ext_reset_s;
	logic supply_rise_s;
	logic supply_fall_s;

	// Cause register and control
	logic [7:0] reset_cause_flags;
	logic [7:0] next_flags;
	logic [7:0] set_mask;
	logic parity_reset_disable;

	// Sequencer
	rsf_state_e state;
	rsf_state_e next_state;
	logic [15:0] hold_count;
	logic por_active;
	logic clear_all;
	logic internal_req;
	logic illegal_hit;
	logic parity_hit;
	logic cause_rd;
	logic cause_byte_rd;
	logic pardis_wr;
	logic pardis_rd;

	// Pin and comparators come from outside the clock, so two flops each
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ext_sync <= '0;
			rise_sync <= '0;
			fall_sync <= '0;
		end else begin
			ext_sync <= {ext_sync[RSF_SYNC_STAGES-2:0], ~ext_reset_n_i};
			rise_sync <= {rise_sync[RSF_SYNC_STAGES-2:0], supply_rise_ok_i};
			fall_sync <= {fall_sync[RSF_SYNC_STAGES-2:0], supply_fall_low_i};
		end
	end

	// Only the last stage of each chain is looked at
	assign ext_reset_s = ext_sync[RSF_SYNC_STAGES-1];
	assign supply_rise_s = rise_sync[RSF_SYNC_STAGES-1];
	assign supply_fall_s = fall_sync[RSF_SYNC_STAGES-1];

	// Power-on reset: latched from reset_i until the rise level is seen,
	// then again whenever the supply falls below the fall level
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			por_active <= 1'b1;
		end else if (supply_fall_s) begin
			por_active <= 1'b1;
		end else if (supply_rise_s) begin
			por_active <= 1'b0;
		end
	end

	// Address decode of processor accesses
	assign cause_rd = bus_i.rd && (bus_i.addr == RSF_CAUSE_ADDR);
	assign cause_byte_rd = cause_rd && !bus_i.bit_access;
	assign pardis_wr = bus_i.wr && (bus_i.addr == RSF_PARDIS_ADDR);
	assign pardis_rd = bus_i.rd && (bus_i.addr == RSF_PARDIS_ADDR);

	assign illegal_hit = src_i.exec_valid &&
		(src_i.exec_opcode == RSF_ILLEGAL_OPCODE) && !src_i.debug_active;

	// Parity resets are suppressed while software has disabled them
	assign parity_hit = src_i.ram_parity && !parity_reset_disable;

	// One bit per internal source; each sets only its own position
	always_comb begin
		set_mask = 8'h00;
		set_mask[RSF_BIT_ILLEGAL] = illegal_hit;
		set_mask[RSF_BIT_WATCHDOG] = src_i.watchdog_timer;
		set_mask[RSF_BIT_PARITY] = parity_hit;
		set_mask[RSF_BIT_ACCESS] = src_i.bad_access;
		set_mask[RSF_BIT_LOWVOLT] = src_i.low_voltage_detector;
	end

	assign internal_req = |set_mask;

	// External pin and power-on reset wipe the whole register
	assign clear_all = ext_reset_s || por_active;

	// Flag update: wipe, else read-clear with a new set winning
	always_comb begin
		next_flags = reset_cause_flags;
		if (clear_all) begin
			next_flags = RSF_CAUSE_RESET;
		end else begin
			if (cause_byte_rd) begin
				next_flags = RSF_CAUSE_RESET;
			end
			next_flags = next_flags | set_mask;
		end
	end

	// Cause register; bus writes never reach it
	// writes ignored
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			reset_cause_flags <= RSF_CAUSE_RESET;
		end else begin
			reset_cause_flags <= next_flags;
		end
	end

	// Sequencer: power hold, stretched internal reset, normal running
	always_comb begin
		next_state = state;
		case (state)
			RSF_ST_POWER: begin
				if (!clear_all) begin
					next_state = RSF_ST_HOLD;
				end
			end
			RSF_ST_HOLD: begin
				if (clear_all) begin
					next_state = RSF_ST_POWER;
				end else if (hold_count == HOLD_LAST && !internal_req) begin
					next_state = RSF_ST_RUN;
				end
			end
			RSF_ST_RUN: begin
				if (clear_all) begin
					next_state = RSF_ST_POWER;
				end else if (internal_req) begin
					next_state = RSF_ST_HOLD;
				end
			end
			default: begin
				next_state = RSF_ST_POWER;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state <= RSF_ST_POWER;
		end else begin
			state <= next_state;
		end
	end

	// Stretch counter restarts on every new request so back-to-back
	// sources yield one long reset rather than a glitchy release
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			hold_count <= 16'h0000;
		end else if (state != RSF_ST_HOLD || internal_req) begin
			hold_count <= 16'h0000;
		end else if (hold_count != HOLD_LAST) begin
			hold_count <= hold_count + 16'h0001;
		end
	end

	// Internal reset output, asserted whenever not running
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			internal_reset_o <= 1'b1;
			por_reset_o <= 1'b1;
		end else begin
			internal_reset_o <= (next_state != RSF_ST_RUN);
			por_reset_o <= por_active;
		end
	end

	// Parity reset disable: software control, cleared by any reset
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			parity_reset_disable <= RSF_PARDIS_RESET;
		end else if (clear_all || internal_req || state != RSF_ST_RUN) begin
			parity_reset_disable <= RSF_PARDIS_RESET;
		end else if (pardis_wr) begin
			parity_reset_disable <= bus_i.wdata[RSF_BIT_PARDIS];
		end
	end

	// Read data is registered, answered one cycle after the strobe;
	// unmapped addresses read as zero
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= RSF_READ_IDLE;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= bus_i.rd;
			if (cause_rd) begin
				rd_data_o <= reset_cause_flags;
			end else if (pardis_rd) begin
				rd_data_o <= {7'h00, parity_reset_disable};
			end else begin
				rd_data_o <= RSF_READ_IDLE;
			end
		end
	end

	// Mirror outputs, straight from flops
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			parity_reset_disable_o <= RSF_PARDIS_RESET;
			reset_cause_flags_o <= RSF_CAUSE_RESET;
		end else begin
			parity_reset_disable_o <= parity_reset_disable;
			reset_cause_flags_o <= reset_cause_flags;
		end
	end

endmodule // rsf_reset_cause

// [rsf_reset_cause_assertions.sv]
// Port checks for the reset cause register and power-on sequencer
module rsf_cause_checker
	import rsf_pkg::*;
#(
	parameter int HOLD_CYCLES = RSF_HOLD_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ext_reset_n_i,
	input wire logic supply_rise_ok_i,
	input wire logic supply_fall_low_i,
	input wire rsf_pkg::rsf_src_s src_i,
	input wire rsf_pkg::rsf_bus_s bus_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic internal_reset_o,
	input wire logic por_reset_o,
	input wire logic parity_reset_disable_o,
	input wire logic [7:0] reset_cause_flags_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Pin idle and supply good long enough for the synchronisers
	sequence quiet;
		(ext_reset_n_i && supply_rise_ok_i && !supply_fall_low_i
			&& !por_reset_o)[*4];
	endsequence
	sequence byte_rd;
		bus_i.rd && !bus_i.bit_access && bus_i.addr == RSF_CAUSE_ADDR;
	endsequence
	wire logic no_src = !(src_i.exec_valid | src_i.watchdog_timer
		| src_i.ram_parity | src_i.bad_access | src_i.low_voltage_detector);
	// Flag shows in the mirror two edges after its source
	property set_flag(logic s, int b);
		quiet ##0 s |-> ##2 reset_cause_flags_o[b];
	endproperty
	a_read_answer: assert property (byte_rd |=> rd_valid_o)
		else $error("byte read not answered");
	a_read_clears: assert property (byte_rd ##0 no_src |-> ##2
		reset_cause_flags_o == 8'h00) else $error("read did not clear");
	a_reserved_zero: assert property (rd_valid_o |->
		rd_data_o[6:5] == 2'h0 && !rd_data_o[3]) else $error("bad bits");
	a_watchdog_set: assert property (set_flag(src_i.watchdog_timer,
		RSF_BIT_WATCHDOG)) else $error("watchdog flag missing");
	a_access_set: assert property (set_flag(src_i.bad_access,
		RSF_BIT_ACCESS)) else $error("access flag missing");
	a_lowvolt_set: assert property (set_flag(src_i.low_voltage_detector,
		RSF_BIT_LOWVOLT)) else $error("low voltage flag missing");
	a_illegal_set: assert property (set_flag(src_i.exec_valid
		&& src_i.exec_opcode == RSF_ILLEGAL_OPCODE && !src_i.debug_active,
		RSF_BIT_ILLEGAL)) else $error("illegal flag missing");
	a_parity_set: assert property (quiet ##0 src_i.ram_parity
		##1 !parity_reset_disable_o |->
		##1 reset_cause_flags_o[RSF_BIT_PARITY])
		else $error("parity flag missing");
	a_flags_held: assert property (quiet ##0 !bus_i.rd |-> ##2
		(reset_cause_flags_o & $past(reset_cause_flags_o))
		== $past(reset_cause_flags_o)) else $error("flag dropped");
	a_por_clears: assert property (por_reset_o |=>
		reset_cause_flags_o == 8'h00) else $error("por left flags");
	// Four low samples: the two-flop chain may still carry an older high
	a_rise_holds: assert property ((!supply_rise_ok_i)[*4] ##0
		por_reset_o |=> por_reset_o) else $error("por released early");
	a_fall_asserts: assert property (supply_fall_low_i[*6] |->
		por_reset_o && internal_reset_o) else $error("no reset on fall");
	a_disable_cleared: assert property (internal_reset_o[*3] |->
		!parity_reset_disable_o) else $error("disable kept in reset");
endmodule // rsf_cause_checker

bind rsf_reset_cause rsf_cause_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
	.clock_i(clock_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
	.supply_rise_ok_i(supply_rise_ok_i),
	.supply_fall_low_i(supply_fall_low_i), .src_i(src_i), .bus_i(bus_i),
	.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
	.internal_reset_o(internal_reset_o), .por_reset_o(por_reset_o),
	.parity_reset_disable_o(parity_reset_disable_o),
	.reset_cause_flags_o(reset_cause_flags_o));

// [rsf_testbench.sv]
// Self-checking bench for the reset cause register block
module testbench import rsf_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 1'b0, reset_i = 1'b1, ext_reset_n_i = 1'b1;
	logic supply_rise_ok_i = 1'b0, supply_fall_low_i = 1'b0;
	rsf_src_s src_i = '0;
	rsf_bus_s bus_i = '0;
	logic [7:0] rd_data_o, reset_cause_flags_o;
	logic rd_valid_o, internal_reset_o, por_reset_o, parity_reset_disable_o;
	int n_errors = 0, tests_run = 0;
	localparam logic [19:0] CA = RSF_CAUSE_ADDR, PA = RSF_PARDIS_ADDR;
	localparam logic [7:0] WD = 8'h01 << RSF_BIT_WATCHDOG;

	rsf_reset_cause #(.HOLD_CYCLES(2)) u_rsf_reset_cause (.clock_i(clock_i),
		.reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
		.supply_rise_ok_i(supply_rise_ok_i),
		.supply_fall_low_i(supply_fall_low_i), .src_i(src_i), .bus_i(bus_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.internal_reset_o(internal_reset_o), .por_reset_o(por_reset_o),
		.parity_reset_disable_o(parity_reset_disable_o),
		.reset_cause_flags_o(reset_cause_flags_o));

	// 40 MHz clock
	always #12.5 clock_i = ~clock_i;

	function automatic logic [7:0] bv(input int b);
		return 8'h01 << b;
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle read strobe, answer looked at one edge later
	task automatic rd(input logic [19:0] a, input logic b, logic [7:0] exp);
		@(posedge clock_i) bus_i <= '{1'b1, 1'b0, b, a, 8'h00};
		@(posedge clock_i) bus_i <= '0;
		#1 chk({7'h00, rd_valid_o}, 8'h01);
		chk(rd_data_o, exp);
	endtask

	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clock_i) bus_i <= '{1'b0, 1'b1, 1'b0, a, d};
		@(posedge clock_i) bus_i <= '0;
	endtask

	// Wait, bounded, for the internal reset to end; outputs are looked
	// at 1 ns after the edge so they are never read as they launch
	task automatic settle();
		#1;
		for (int i = 0; i < 80 && internal_reset_o !== 1'b0; i++) begin
			@(posedge clock_i);
			#1;
		end
		repeat (2) @(posedge clock_i);
		#1 chk({7'h00, internal_reset_o}, 8'h00);
	endtask

	// Kinds: 0 dog, 1 parity, 2 access, 3 low volt, 4 FF, 5 FF debug, 6 op 00
	task automatic pulse(input int k, input logic fires);
		rsf_src_s s;
		s = '0;
		case (k)
			0: s.watchdog_timer = 1'b1;
			1: s.ram_parity = 1'b1;
			2: s.bad_access = 1'b1;
			3: s.low_voltage_detector = 1'b1;
			default: begin
				s.exec_valid = 1'b1;
				s.exec_opcode = (k == 6) ? 8'h00 : RSF_ILLEGAL_OPCODE;
				s.debug_active = (k == 5);
			end
		endcase
		@(posedge clock_i) src_i <= s;
		@(posedge clock_i) src_i <= '0;
		@(posedge clock_i);
		#1 chk({7'h00, internal_reset_o}, {7'h00, fires});
		settle();
	endtask

	task automatic final_report();
		$display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence; supply comes up a few cycles after reset
	initial begin
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		#1 chk({7'h00, internal_reset_o}, 8'h01);
		@(posedge clock_i) supply_rise_ok_i <= 1'b1;
		settle();
		chk({7'h00, por_reset_o}, 8'h00);
		rd(CA, 1'b0, 8'h00);
		rd(PA, 1'b0, 8'h00);
		pulse(0, 1'b1);
		pulse(2, 1'b1);
		rd(CA, 1'b0, WD | bv(RSF_BIT_ACCESS));
		pulse(1, 1'b1);
		pulse(3, 1'b1);
		pulse(4, 1'b1);
		rd(CA, 1'b0, bv(2) | bv(0) | bv(RSF_BIT_ILLEGAL));
		rd(CA, 1'b0, 8'h00);
		pulse(5, 1'b0);
		pulse(6, 1'b0);
		rd(CA, 1'b0, 8'h00);
		pulse(0, 1'b1);
		wr(CA, 8'hFF);
		rd(CA, 1'b1, WD);
		chk(reset_cause_flags_o, WD);
		rd(CA, 1'b0, WD);
		wr(PA, 8'h01);
		rd(PA, 1'b0, 8'h01);
		chk({7'h00, parity_reset_disable_o}, 8'h01);
		pulse(1, 1'b0);
		rd(CA, 1'b0, 8'h00);
		pulse(0, 1'b1);
		rd(PA, 1'b0, 8'h00);
		rd(20'h00100, 1'b0, 8'h00);
		rd(CA, 1'b0, WD);
		// Pin pulled low clears the watchdog flag set before it
		pulse(0, 1'b1);
		@(posedge clock_i) ext_reset_n_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		ext_reset_n_i <= 1'b1;
		settle();
		rd(CA, 1'b0, 8'h00);
		// Supply dip forces a power-on reset
		pulse(3, 1'b1);
		@(posedge clock_i) supply_fall_low_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		#1 chk({7'h00, por_reset_o}, 8'h01);
		@(posedge clock_i) supply_fall_low_i <= 1'b0;
		settle();
		rd(CA, 1'b0, 8'h00);
		final_report();
	end

	// Cut a hung run short
	initial begin
		#50us;
		n_errors++;
		final_report();
	end
endmodule // testbench
